/* verilog/fsms_defs.vh */
`ifndef FSMS_DEFS_VH
`define FSMS_DEFS_VH

// Scrambler option codes
`define FSMS_OPT_W 3
`define FSMS_OPT_308 3'h0
`define FSMS_OPT_309 3'h1
`define FSMS_OPT_V35 3'h2
`define FSMS_OPT_STD 3'h3
`define FSMS_OPT_ALT_V35 3'h4
`define FSMS_OPT_ALT_STD 3'h5

// Scrambler selection codes
`define FSMS_SEL_W 2
`define FSMS_SEL_SELF_STD 2'h0
`define FSMS_SEL_V35 2'h1
`define FSMS_SEL_IBS_FRAME 2'h2
`define FSMS_SEL_RS_FRAME 2'h3

// Multiplexer modes
`define FSMS_MUX_W 2
`define FSMS_MUX_OFF 2'h0
`define FSMS_MUX_STANDARD 2'h1
`define FSMS_MUX_ENHANCED 2'h2
`define FSMS_MUX_CUSTOM 2'h3

// Configuration word layout
`define FSMS_CFG_W 12
`define FSMS_CFG_RST 12'h000
`define FSMS_CFG_TX_MUX 1:0
`define FSMS_CFG_TX_RS 2
`define FSMS_CFG_TX_OPT 5:3
`define FSMS_CFG_RX_MUX 7:6
`define FSMS_CFG_RX_RS 8
`define FSMS_CFG_RX_OPT 11:9

// Framing
`define FSMS_MFRAME_LEN 6'h3F
`define FSMS_LOCK_FRAMES 8'h02
`define FSMS_LOCK_FRAMES_SYNC 8'h80

// Rates in units of 100 bit/s
`define FSMS_RATE_W 16
`define FSMS_AGG_MAX_X15 20'hB42D0
`define FSMS_TERM_CLAMP 16'hB42D
`define FSMS_MUX_SHIFT 4'h0
`define FSMS_MUX_DEN 20'h0000F

// Beeps
`define FSMS_BEEP_MS 50
`define FSMS_CLK_KHZ 10000
`define FSMS_BEEP_HALVES 3'h7

`endif

/* verilog/fsms_sync.v */
`timescale 1ns/1ps
module fsms_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Data
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

/* verilog/fsms_sel.v */
`timescale 1ns/1ps
`include "fsms_defs.vh"
module fsms_sel (
    // Direction settings
    input wire [`FSMS_MUX_W-1:0] mux_mode,
    input wire rs_on,
    input wire [`FSMS_OPT_W-1:0] option,
    // Selection
    output wire [`FSMS_SEL_W-1:0] sel,
    output wire invert,
    output wire frame_sync
);
    wire mux_on;

    function [`FSMS_SEL_W-1:0] pick;
        input m;
        input r;
        input [`FSMS_OPT_W-1:0] o;
        begin
            case (o)
                `FSMS_OPT_308: begin
                    if (m)
                        pick = `FSMS_SEL_IBS_FRAME;
                    else if (r)
                        pick = `FSMS_SEL_RS_FRAME;
                    else
                        pick = `FSMS_SEL_SELF_STD;
                end
                `FSMS_OPT_309: begin
                    if (m)
                        pick = `FSMS_SEL_IBS_FRAME;
                    else
                        pick = `FSMS_SEL_SELF_STD;
                end
                `FSMS_OPT_V35, `FSMS_OPT_ALT_V35: pick = `FSMS_SEL_V35;
                default: pick = `FSMS_SEL_SELF_STD;
            endcase
        end
    endfunction

    assign mux_on = (mux_mode != `FSMS_MUX_OFF);
    assign sel = pick(mux_on, rs_on, option);
    assign invert = (option == `FSMS_OPT_ALT_V35) || (option == `FSMS_OPT_ALT_STD);
    assign frame_sync = (sel == `FSMS_SEL_IBS_FRAME) || (sel == `FSMS_SEL_RS_FRAME);
endmodule

/* verilog/fsms_top.v */
`timescale 1ns/1ps
`include "fsms_defs.vh"
module fsms_top #(
    parameter BEEP_CYCLES = `FSMS_BEEP_MS * `FSMS_CLK_KHZ
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Configuration write and non-volatile store
    input wire cfg_wr,
    input wire [`FSMS_CFG_W-1:0] cfg_wr_data,
    input wire [`FSMS_CFG_W-1:0] nv_restore_data,
    output reg nv_wr_en_reg,
    output reg [`FSMS_CFG_W-1:0] nv_wr_data_reg,
    output reg [`FSMS_CFG_W-1:0] cfg_reg,
    // Outer code options
    input wire turbo_product_fec_enable,
    output reg outer_code_conflict_reg,
    // Scrambler selection
    output reg [`FSMS_SEL_W-1:0] tx_scr_sel_reg,
    output reg tx_invert_reg,
    output reg [`FSMS_SEL_W-1:0] rx_scr_sel_reg,
    output reg rx_invert_reg,
    // Rates, units of 100 bit/s
    input wire [`FSMS_RATE_W-1:0] term_rate,
    input wire [7:0] rs_n,
    input wire [7:0] rs_k,
    output reg [`FSMS_RATE_W-1:0] term_rate_eff_reg,
    output reg [19:0] agg_rate_reg,
    output reg beep_reg,
    // Transmit framing
    input wire tx_frame_strobe,
    output reg tx_mframe_bit_reg,
    // Receive link
    input wire rx_link_clk,
    input wire rx_frame_mark,
    input wire rx_frame_ok,
    output reg rx_frame_lock_reg,
    // Overhead service channel, data path side
    input wire svc_rx_bit,
    output reg svc_tx_bit_reg,
    output reg svc_tx_bit_valid_reg,
    // Overhead service channel, pins
    input wire overhead_service_channel_tx_data,
    input wire svc_rts,
    input wire svc_dtr,
    output reg overhead_service_channel_rx_data_reg,
    output reg svc_tx_clk_reg,
    output reg svc_rx_clk_reg,
    output reg svc_cts_reg,
    output reg svc_dsr_reg,
    output reg svc_dcd_reg
);
    localparam [19:0] BEEP_CNT = BEEP_CYCLES[19:0];

    // Beep state, one-hot
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_BEEP = 2'b10;

    wire [5:0] pin_s;
    wire link_s;
    wire mark_s;
    wire ok_s;
    wire svc_txd_s;
    wire rts_s;
    wire dtr_s;
    wire tx_rs_on;
    wire rx_rs_on;
    wire [`FSMS_SEL_W-1:0] tx_sel;
    wire [`FSMS_SEL_W-1:0] rx_sel;
    wire tx_inv;
    wire rx_inv;
    wire tx_fsync;
    wire rx_fsync;
    wire rx_mux_std;
    wire tx_mux_std;
    wire tx_mux_ovh;
    wire [19:0] term_x16;
    wire exceed;
    wire [`FSMS_RATE_W-1:0] term_eff;
    wire [19:0] agg_mux;
    wire [27:0] agg_rs_prod;
    wire [27:0] agg_rs;
    wire [19:0] agg_next;
    wire link_rise;
    wire link_fall;
    wire [7:0] lock_need;

    reg restore_done_reg;
    reg link_d_reg;
    reg [5:0] tx_fcnt_reg;
    reg [7:0] rx_fcnt_reg;
    reg exceed_d_reg;
    reg [1:0] beep_state_reg;
    reg [19:0] beep_cnt_reg;
    reg [2:0] beep_half_reg;

    fsms_sync #(
        .W(6)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({rx_link_clk, rx_frame_mark, rx_frame_ok,
            overhead_service_channel_tx_data, svc_rts, svc_dtr}),
        .sync_out(pin_s)
    );

    assign link_s = pin_s[5];
    assign mark_s = pin_s[4];
    assign ok_s = pin_s[3];
    assign svc_txd_s = pin_s[2];
    assign rts_s = pin_s[1];
    assign dtr_s = pin_s[0];

    // Outer code exclusivity
    assign tx_rs_on = cfg_reg[`FSMS_CFG_TX_RS] & ~turbo_product_fec_enable;
    assign rx_rs_on = cfg_reg[`FSMS_CFG_RX_RS] & ~turbo_product_fec_enable;

    fsms_sel u_tx_sel (
        .mux_mode(cfg_reg[`FSMS_CFG_TX_MUX]),
        .rs_on(tx_rs_on),
        .option(cfg_reg[`FSMS_CFG_TX_OPT]),
        .sel(tx_sel),
        .invert(tx_inv),
        .frame_sync(tx_fsync)
    );

    fsms_sel u_rx_sel (
        .mux_mode(cfg_reg[`FSMS_CFG_RX_MUX]),
        .rs_on(rx_rs_on),
        .option(cfg_reg[`FSMS_CFG_RX_OPT]),
        .sel(rx_sel),
        .invert(rx_inv),
        .frame_sync(rx_fsync)
    );

    // Configuration restore at release, save on each write after the restore cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            restore_done_reg <= 1'b0;
            cfg_reg <= `FSMS_CFG_RST;
            nv_wr_en_reg <= 1'b0;
            nv_wr_data_reg <= `FSMS_CFG_RST;
        end else begin
            nv_wr_en_reg <= 1'b0;
            if (!restore_done_reg) begin
                restore_done_reg <= 1'b1;
                cfg_reg <= nv_restore_data;
            end else if (cfg_wr) begin
                cfg_reg <= cfg_wr_data;
                nv_wr_en_reg <= 1'b1;
                nv_wr_data_reg <= cfg_wr_data;
            end
        end
    end

    // Selection outputs, per direction
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_scr_sel_reg <= `FSMS_SEL_SELF_STD;
            tx_invert_reg <= 1'b0;
            rx_scr_sel_reg <= `FSMS_SEL_SELF_STD;
            rx_invert_reg <= 1'b0;
            outer_code_conflict_reg <= 1'b0;
        end else begin
            tx_scr_sel_reg <= tx_sel;
            tx_invert_reg <= tx_inv;
            rx_scr_sel_reg <= rx_sel;
            rx_invert_reg <= rx_inv;
            outer_code_conflict_reg <= turbo_product_fec_enable &
                (cfg_reg[`FSMS_CFG_TX_RS] | cfg_reg[`FSMS_CFG_RX_RS]);
        end
    end

    // Aggregate rate
    assign tx_mux_ovh = (cfg_reg[`FSMS_CFG_TX_MUX] == `FSMS_MUX_STANDARD) ||
        (cfg_reg[`FSMS_CFG_TX_MUX] == `FSMS_MUX_ENHANCED);
    assign term_x16 = {term_rate, `FSMS_MUX_SHIFT};
    assign exceed = tx_mux_ovh && (term_x16 > `FSMS_AGG_MAX_X15);
    assign term_eff = exceed ? `FSMS_TERM_CLAMP : term_rate;
    assign agg_mux = tx_mux_ovh ? ({term_eff, `FSMS_MUX_SHIFT} / `FSMS_MUX_DEN) :
        {4'h0, term_eff};
    assign agg_rs_prod = agg_mux * rs_n;
    assign agg_rs = (rs_k == 8'h00) ? {8'h00, agg_mux} : (agg_rs_prod / rs_k);
    assign agg_next = tx_rs_on ? agg_rs[19:0] : agg_mux;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            term_rate_eff_reg <= {`FSMS_RATE_W{1'b0}};
            agg_rate_reg <= 20'h00000;
            exceed_d_reg <= 1'b0;
        end else begin
            term_rate_eff_reg <= term_eff;
            agg_rate_reg <= agg_next;
            exceed_d_reg <= exceed;
        end
    end

    // Four beeps on a new clamp while idle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            beep_state_reg <= ST_IDLE;
            beep_cnt_reg <= 20'h00000;
            beep_half_reg <= 3'h0;
            beep_reg <= 1'b0;
        end else begin
            case (beep_state_reg)
                ST_IDLE: begin
                    beep_reg <= 1'b0;
                    if (exceed && !exceed_d_reg) begin
                        beep_state_reg <= ST_BEEP;
                        beep_cnt_reg <= 20'h00000;
                        beep_half_reg <= 3'h0;
                        beep_reg <= 1'b1;
                    end
                end
                ST_BEEP: begin
                    if (beep_cnt_reg == BEEP_CNT - 20'h00001) begin
                        beep_cnt_reg <= 20'h00000;
                        if (beep_half_reg == `FSMS_BEEP_HALVES) begin
                            beep_state_reg <= ST_IDLE;
                            beep_reg <= 1'b0;
                        end else begin
                            beep_half_reg <= beep_half_reg + 3'h1;
                            beep_reg <= ~beep_reg;
                        end
                    end else begin
                        beep_cnt_reg <= beep_cnt_reg + 20'h00001;
                    end
                end
                default: begin
                    beep_state_reg <= ST_IDLE;
                    beep_reg <= 1'b0;
                end
            endcase
        end
    end

    // Transmit multi-frame bit
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_fcnt_reg <= 6'h00;
            tx_mframe_bit_reg <= 1'b0;
        end else begin
            tx_mframe_bit_reg <= 1'b0;
            if (tx_frame_strobe) begin
                tx_fcnt_reg <= tx_fcnt_reg + 6'h01;
                if (tx_fcnt_reg == `FSMS_MFRAME_LEN)
                    tx_mframe_bit_reg <= tx_fsync;
            end
        end
    end

    // Receive link edges and frame lock
    assign link_rise = link_s & ~link_d_reg;
    assign link_fall = ~link_s & link_d_reg;
    assign lock_need = rx_fsync ? `FSMS_LOCK_FRAMES_SYNC : `FSMS_LOCK_FRAMES;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            link_d_reg <= 1'b0;
            rx_fcnt_reg <= 8'h00;
            rx_frame_lock_reg <= 1'b0;
        end else begin
            link_d_reg <= link_s;
            if (link_rise && mark_s) begin
                if (!ok_s) begin
                    rx_fcnt_reg <= 8'h00;
                    rx_frame_lock_reg <= 1'b0;
                end else if (rx_fcnt_reg < lock_need) begin
                    rx_fcnt_reg <= rx_fcnt_reg + 8'h01;
                    if (rx_fcnt_reg + 8'h01 >= lock_need)
                        rx_frame_lock_reg <= 1'b1;
                end
            end
        end
    end

    // Service channel
    assign tx_mux_std = (cfg_reg[`FSMS_CFG_TX_MUX] == `FSMS_MUX_STANDARD);
    assign rx_mux_std = (cfg_reg[`FSMS_CFG_RX_MUX] == `FSMS_MUX_STANDARD);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            svc_tx_clk_reg <= 1'b0;
            svc_rx_clk_reg <= 1'b0;
            svc_tx_bit_reg <= 1'b0;
            svc_tx_bit_valid_reg <= 1'b0;
            overhead_service_channel_rx_data_reg <= 1'b0;
            svc_cts_reg <= 1'b0;
            svc_dsr_reg <= 1'b0;
            svc_dcd_reg <= 1'b0;
        end else begin
            svc_tx_bit_valid_reg <= 1'b0;
            svc_tx_clk_reg <= tx_mux_std & link_s;
            svc_rx_clk_reg <= rx_mux_std & link_s;
            svc_cts_reg <= ~tx_mux_std & rts_s;
            svc_dsr_reg <= ~rx_mux_std & dtr_s;
            svc_dcd_reg <= ~rx_mux_std & rx_frame_lock_reg;
            if (tx_mux_std && link_rise) begin
                svc_tx_bit_reg <= svc_txd_s;
                svc_tx_bit_valid_reg <= 1'b1;
            end else if (!tx_mux_std && link_rise && rts_s) begin
                svc_tx_bit_reg <= svc_txd_s;
                svc_tx_bit_valid_reg <= 1'b1;
            end
            if (link_fall)
                overhead_service_channel_rx_data_reg <= svc_rx_bit;
        end
    end
endmodule

/* verif/fsms_top_props.sv */
`timescale 1ns/1ps
`include "fsms_defs.vh"
module fsms_top_props (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Configuration
    input wire cfg_wr,
    input wire [`FSMS_CFG_W-1:0] cfg_wr_data,
    input wire [`FSMS_CFG_W-1:0] cfg_reg,
    input wire nv_wr_en_reg,
    input wire [`FSMS_CFG_W-1:0] nv_wr_data_reg,
    input wire turbo_product_fec_enable,
    // Selection and rate
    input wire [`FSMS_SEL_W-1:0] tx_scr_sel_reg,
    input wire tx_invert_reg,
    input wire [`FSMS_SEL_W-1:0] rx_scr_sel_reg,
    input wire [`FSMS_RATE_W-1:0] term_rate,
    input wire [`FSMS_RATE_W-1:0] term_rate_eff_reg,
    // Framing and service channel
    input wire tx_frame_strobe,
    input wire tx_mframe_bit_reg,
    input wire overhead_service_channel_rx_data_reg,
    input wire svc_tx_bit_valid_reg,
    input wire svc_tx_clk_reg,
    input wire svc_rx_clk_reg
);
    reg started_reg;
    wire [2:0] t_opt = cfg_reg[5:3];
    wire [1:0] t_mux = cfg_reg[1:0];
    wire t_alt = t_opt == `FSMS_OPT_ALT_V35 || t_opt == `FSMS_OPT_ALT_STD;
    wire t_std = t_mux == `FSMS_MUX_STANDARD;
    wire r_std = cfg_reg[7:6] == `FSMS_MUX_STANDARD;
    wire enh = t_mux == `FSMS_MUX_ENHANCED && cfg_reg[7:6] == `FSMS_MUX_ENHANCED;
    wire quiet = started_reg && !turbo_product_fec_enable;
    // Marks edges after the restore edge
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_CFG_LOAD: assert property (started_reg && cfg_wr |=>
        cfg_reg == $past(cfg_wr_data) && nv_wr_en_reg && nv_wr_data_reg == $past(cfg_wr_data))
        else $error("config load or store wrong");
    AST_TX_IBS: assert property (started_reg && t_opt <= `FSMS_OPT_309 && t_mux != 2'h0 |=>
        tx_scr_sel_reg == `FSMS_SEL_IBS_FRAME) else $error("tx mux frame scrambler wrong");
    AST_TX_RS: assert property (quiet && !$past(turbo_product_fec_enable)
        && t_opt == `FSMS_OPT_308 && t_mux == 2'h0 && cfg_reg[2]
        |=> tx_scr_sel_reg == `FSMS_SEL_RS_FRAME) else $error("tx outer code scrambler wrong");
    AST_TX_SELF: assert property (started_reg && t_opt <= `FSMS_OPT_309 && t_mux == 2'h0
        && (!cfg_reg[2] || t_opt == `FSMS_OPT_309) |=> tx_scr_sel_reg == `FSMS_SEL_SELF_STD)
        else $error("tx self sync scrambler wrong");
    AST_TX_INV: assert property (started_reg |=> tx_invert_reg == $past(t_alt))
        else $error("tx inversion wrong");
    AST_RX_RS: assert property (quiet && !$past(turbo_product_fec_enable)
        && cfg_reg[11:9] == `FSMS_OPT_308 && cfg_reg[7:6] == 2'h0 && cfg_reg[8]
        |=> rx_scr_sel_reg == `FSMS_SEL_RS_FRAME) else $error("rx outer code scrambler wrong");
    AST_OUTER: assert property (started_reg && turbo_product_fec_enable
        && $past(turbo_product_fec_enable) |=> tx_scr_sel_reg != `FSMS_SEL_RS_FRAME
        && rx_scr_sel_reg != `FSMS_SEL_RS_FRAME) else $error("outer codes both active");
    AST_MFRAME: assert property (tx_mframe_bit_reg |->
        $past(tx_frame_strobe) ##1 !tx_mframe_bit_reg [*8]) else $error("multi-frame bit wrong");
    AST_CLAMP: assert property (started_reg && (t_std || t_mux == `FSMS_MUX_ENHANCED)
        && term_rate > `FSMS_TERM_CLAMP |=> term_rate_eff_reg == `FSMS_TERM_CLAMP)
        else $error("rate not clamped");
    AST_RX_FALL: assert property (r_std && $past(r_std)
        && $changed(overhead_service_channel_rx_data_reg) |-> !svc_rx_clk_reg
        && ($past(svc_rx_clk_reg) || $past(svc_rx_clk_reg, 2))) else $error("rx data off edge");
    AST_TX_VALID: assert property (t_std && r_std && svc_tx_bit_valid_reg |-> svc_tx_clk_reg
        && (!$past(svc_tx_clk_reg) || !$past(svc_tx_clk_reg, 2))) else $error("tx bit off edge");
    AST_ENH_NOCLK: assert property (enh && $past(enh) && $past(enh, 2) |->
        !svc_tx_clk_reg && !svc_rx_clk_reg) else $error("clocks run in buffered mode");
endmodule

bind fsms_top fsms_top_props u_props (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_wr_data(cfg_wr_data), .cfg_reg(cfg_reg), .nv_wr_en_reg(nv_wr_en_reg),
    .nv_wr_data_reg(nv_wr_data_reg), .turbo_product_fec_enable(turbo_product_fec_enable),
    .tx_scr_sel_reg(tx_scr_sel_reg), .tx_invert_reg(tx_invert_reg),
    .rx_scr_sel_reg(rx_scr_sel_reg), .term_rate(term_rate),
    .term_rate_eff_reg(term_rate_eff_reg), .tx_frame_strobe(tx_frame_strobe),
    .tx_mframe_bit_reg(tx_mframe_bit_reg),
    .overhead_service_channel_rx_data_reg(overhead_service_channel_rx_data_reg),
    .svc_tx_bit_valid_reg(svc_tx_bit_valid_reg), .svc_tx_clk_reg(svc_tx_clk_reg),
    .svc_rx_clk_reg(svc_rx_clk_reg));

/* verif/fsms_far_end.sv */
`timescale 1ns/1ps
module fsms_far_end (
    // Control from bench
    input wire run,
    input wire good,
    // Link toward the device
    output logic rx_link_clk,
    output logic rx_frame_mark,
    output logic rx_frame_ok,
    output logic overhead_service_channel_tx_data
);
    logic [1:0] bit_cnt;
    initial begin
        rx_link_clk = 1'b0;
        rx_frame_mark = 1'b0;
        rx_frame_ok = 1'b0;
        overhead_service_channel_tx_data = 1'b0;
        bit_cnt = 2'h0;
        forever begin
            wait (run === 1'b1);
            #400 rx_link_clk = 1'b1;
            #400 rx_link_clk = 1'b0;
            // New bit and frame mark on the falling edge
            bit_cnt = bit_cnt + 2'h1;
            rx_frame_mark = (bit_cnt == 2'h0);
            rx_frame_ok = good;
            overhead_service_channel_tx_data = ~overhead_service_channel_tx_data;
            if (run !== 1'b1) begin
                rx_frame_mark = ~rx_frame_mark;
                rx_frame_ok = ~rx_frame_ok;
            end
        end
    end
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic clk, rst, cfg_wr, turbo_product_fec_enable, tx_frame_strobe, svc_rx_bit;
    logic svc_rts, svc_dtr, run, good, nv_wr_en_reg, outer_code_conflict_reg;
    logic [11:0] cfg_wr_data, nv_restore_data, nv_wr_data_reg, cfg_reg;
    logic [15:0] term_rate, term_rate_eff_reg;
    logic [7:0] rs_n, rs_k;
    logic [19:0] agg_rate_reg, mf_cnt, hi;
    logic [1:0] tx_scr_sel_reg, rx_scr_sel_reg;
    logic tx_invert_reg, rx_invert_reg, beep_reg, tx_mframe_bit_reg, rx_frame_lock_reg;
    logic svc_tx_bit_reg, svc_tx_bit_valid_reg, rx_link_clk, rx_frame_mark, rx_frame_ok;
    logic overhead_service_channel_tx_data, overhead_service_channel_rx_data_reg;
    logic svc_tx_clk_reg, svc_rx_clk_reg, svc_cts_reg, svc_dsr_reg, svc_dcd_reg;
    int fail_count, checked;
    // Config word beside tx sel, tx inv, rx sel, rx inv
    logic [17:0] rows [11] = '{{12'hA40, 6'h01}, {12'h901, 6'h23}, {12'h644, 6'h30},
        {12'h546, 6'h22}, {12'h2CC, 6'h04}, {12'h30B, 6'h20}, {12'h195, 6'h14},
        {12'h119, 6'h06}, {12'h064, 6'h1C}, {12'h029, 6'h08}, {12'hE71, 6'h00}};

    fsms_top #(.BEEP_CYCLES(4)) dut (.clk, .rst, .cfg_wr, .cfg_wr_data, .nv_restore_data,
        .nv_wr_en_reg, .nv_wr_data_reg, .cfg_reg, .turbo_product_fec_enable,
        .outer_code_conflict_reg, .tx_scr_sel_reg, .tx_invert_reg, .rx_scr_sel_reg,
        .rx_invert_reg, .term_rate, .rs_n, .rs_k, .term_rate_eff_reg, .agg_rate_reg,
        .beep_reg, .tx_frame_strobe, .tx_mframe_bit_reg, .rx_link_clk, .rx_frame_mark,
        .rx_frame_ok, .rx_frame_lock_reg, .svc_rx_bit, .svc_tx_bit_reg, .svc_tx_bit_valid_reg,
        .overhead_service_channel_tx_data, .svc_rts, .svc_dtr,
        .overhead_service_channel_rx_data_reg, .svc_tx_clk_reg, .svc_rx_clk_reg, .svc_cts_reg,
        .svc_dsr_reg, .svc_dcd_reg);
    fsms_far_end partner (.run, .good, .rx_link_clk, .rx_frame_mark, .rx_frame_ok,
        .overhead_service_channel_tx_data);

    task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic write_cfg(input logic [11:0] w);
        @(posedge clk) cfg_wr <= 1'b1;
        cfg_wr_data <= w;
        @(posedge clk) cfg_wr <= 1'b0;
        #1 check("nv_store", {nv_wr_en_reg, nv_wr_data_reg}, {1'b1, w});
        tick(1);
    endtask
    task automatic rate(input logic [11:0] w, input logic [15:0] t, e, input logic [19:0] a);
        write_cfg(w);
        @(posedge clk) term_rate <= t;
        tick(3);
        check("term_eff", term_rate_eff_reg, e);
        check("agg", agg_rate_reg, a);
    endtask
    task automatic frames(input logic [11:0] w, input logic [19:0] e);
        write_cfg(w);
        mf_cnt = 20'h00000;
        repeat (128) begin
            @(posedge clk) tx_frame_strobe <= 1'b1;
            @(posedge clk) tx_frame_strobe <= 1'b0;
        end
        tick(3);
        check("mframe", mf_cnt, e);
    endtask
    task automatic wait_mark(input int k);
        repeat (k) @(posedge rx_frame_mark);
        tick(20);
    endtask
    task automatic lock_run(input logic [11:0] w, input int k);
        write_cfg(w);
        @(posedge clk) good <= 1'b0;
        wait_mark(2);
        check("lock_clr", rx_frame_lock_reg, 1'b0);
        @(posedge clk) good <= 1'b1;
        wait_mark(k - 1);
        check("lock_early", rx_frame_lock_reg, 1'b0);
        wait_mark(1);
        check("lock", rx_frame_lock_reg, 1'b1);
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) svc_rx_bit <= ~svc_rx_bit;
    always @(negedge clk) begin
        if (tx_mframe_bit_reg === 1'b1) mf_cnt = mf_cnt + 20'h00001;
        if (svc_tx_bit_valid_reg === 1'b1)
            check("svc_tx", svc_tx_bit_reg, overhead_service_channel_tx_data);
    end
    initial begin
        #3000000;
        fail_count++;
        wrap_up();
    end

    initial begin
        {rst, cfg_wr, turbo_product_fec_enable, tx_frame_strobe, svc_rx_bit} = 5'h10;
        {svc_rts, svc_dtr, run, good} = 4'h1;
        {cfg_wr_data, nv_restore_data} = {12'h000, 12'h2CC};
        {term_rate, rs_n, rs_k} = {16'h2BF2, 8'h7E, 8'h70};
        {fail_count, checked, mf_cnt} = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1 check("reset_out", {tx_scr_sel_reg, rx_scr_sel_reg, nv_wr_en_reg, beep_reg}, 0);
        tick(3);
        check("restore", {cfg_reg, tx_scr_sel_reg, rx_scr_sel_reg}, {12'h2CC, 4'h2});
        foreach (rows[i]) begin
            write_cfg(rows[i][17:6]);
            check("sel", {tx_scr_sel_reg, tx_invert_reg, rx_scr_sel_reg, rx_invert_reg},
                rows[i][5:0]);
        end
        write_cfg(12'h104);
        @(posedge clk) turbo_product_fec_enable <= 1'b1;
        tick(3);
        check("turbo", {tx_scr_sel_reg, rx_scr_sel_reg, outer_code_conflict_reg}, 5'h01);
        @(posedge clk) turbo_product_fec_enable <= 1'b0;
        tick(3);
        check("outer", {tx_scr_sel_reg, rx_scr_sel_reg, outer_code_conflict_reg}, 5'h1E);
        rate(12'h006, 16'h2BF2, 16'h2BF2, 20'h034BC);
        rate(12'h000, 16'h2BF2, 16'h2BF2, 20'h02BF2);
        rate(12'h001, 16'h3A98, 16'h3A98, 20'h03E80);
        @(posedge clk) term_rate <= 16'hBB80;
        hi = 20'h00000;
        repeat (60) begin
            @(negedge clk);
            if (beep_reg === 1'b1) hi = hi + 20'h00001;
        end
        check("beep", hi, 20'h00010);
        check("clamp", {term_rate_eff_reg, agg_rate_reg}, {16'hB42D, 20'h0C030});
        frames(12'h041, 20'h00002);
        frames(12'h659, 20'h00000);
        @(negedge clk) run <= 1'b1;
        lock_run(12'h659, 2);
        lock_run(12'h041, 128);
        write_cfg(12'h082);
        @(posedge clk) {svc_rts, svc_dtr} <= 2'h2;
        tick(8);
        check("hs_a", {svc_cts_reg, svc_dsr_reg, svc_tx_clk_reg, svc_rx_clk_reg}, 4'h8);
        check("dcd_a", svc_dcd_reg, 1'b1);
        @(posedge clk) {svc_rts, svc_dtr} <= 2'h1;
        tick(8);
        check("hs_b", {svc_cts_reg, svc_dsr_reg, svc_tx_clk_reg, svc_rx_clk_reg}, 4'h4);
        check("dcd_b", svc_dcd_reg, 1'b1);
        @(posedge clk) run <= 1'b0;
        tick(8);
        // Reset after run is dropped and the link stops, with a new stored word
        @(posedge clk) rst <= 1'b1;
        nv_restore_data <= 12'h546;
        tick(2);
        check("reset_mid", {tx_scr_sel_reg, rx_scr_sel_reg, rx_frame_lock_reg, svc_dcd_reg}, 0);
        @(posedge clk) rst <= 1'b0;
        tick(3);
        check("restore_mid", {cfg_reg, tx_scr_sel_reg, rx_scr_sel_reg}, {12'h546, 4'h9});
        wrap_up();
    end
endmodule
